/* File: hdl/wop_pkg.sv */
package wop_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 8;
  localparam logic [3:0]  CFG_OFS  = 4'h0;
  localparam logic [3:0]  STAT_OFS = 4'h1;

  // ---------------------------------------------------------------
  // Option register fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_WDG_DISABLE = 0;
  localparam int unsigned BIT_STOP_ENABLE = 1;
  localparam int unsigned BIT_WDG_SHORT   = 2;
  localparam int unsigned BIT_FAST_WAKE   = 3;
  localparam int unsigned BIT_UV_POWER    = 4;
  localparam int unsigned BIT_UV_RST_EN   = 5;
  localparam int unsigned BIT_UV_IN_STOP  = 7;
  localparam logic [7:0]  CFG_MASK        = 8'hBF;
  localparam logic [7:0]  CFG_RESET       = 8'h30;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int unsigned STAT_LOCK     = 0;
  localparam int unsigned STAT_UV_RESET = 1;
  localparam int unsigned STAT_STOP_REC = 2;
  localparam int unsigned STAT_UV_BELOW = 3;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W        = 18;
  localparam int unsigned UV_QUAL_CYC  = 9;
  localparam int unsigned STOP_FAST    = 32;
  localparam int unsigned STOP_SLOW    = 4096;
  localparam int unsigned WDG_SHORT    = 8176;
  localparam int unsigned WDG_LONG     = 262128;

endpackage : wop_pkg

/* File: hdl/wop_uv_filter.sv */
`timescale 1ns/100ps

module wop_uv_filter #(
  parameter int unsigned QUAL = wop_pkg::UV_QUAL_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic below_falling,
  input  wire logic above_rising,
  output logic      reset_req
);

  logic [3:0] cnt_r;

  // ---------------------------------------------------------------
  // Qualify the low supply, then hold until it recovers
  // ---------------------------------------------------------------
  // A short dip resets the count, so noise never trips the reset.
  always_ff @(posedge clk)
  begin
    if (rst || !enable || !below_falling)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'(QUAL))
      cnt_r <= cnt_r + 4'h1; // RL4
  end

  always_ff @(posedge clk)
  begin
    if (rst || !enable)
      reset_req <= 1'b0;
    else if (below_falling && cnt_r == 4'(QUAL - 1))
      reset_req <= 1'b1; // RL4
    else if (above_rising)
      reset_req <= 1'b0; // RL5
  end

  property p_nine_cycles;
    @(posedge clk) disable iff (rst)
      (enable && below_falling)[*8] ##1 (enable && below_falling) |=> reset_req;
  endproperty
  a_nine_cycles: assert property (p_nine_cycles) // RL4
    else $error("Undervolt reset missing after nine low cycles.");

  property p_not_early;
    @(posedge clk) disable iff (rst)
      $rose(reset_req) |-> $past(cnt_r) == 4'(QUAL - 1);
  endproperty
  a_not_early: assert property (p_not_early) // RL4
    else $error("Undervolt reset raised before qualification.");

  property p_hold;
    @(posedge clk) disable iff (rst)
      reset_req && enable && !above_rising |=> reset_req;
  endproperty
  a_hold: assert property (p_hold) // RL5
    else $error("Undervolt reset released before supply recovered.");

endmodule : wop_uv_filter

/* File: hdl/wop_xtal_timer.sv */
`timescale 1ns/100ps

module wop_xtal_timer #(
  parameter int unsigned CNT_W = wop_pkg::CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic             repeat_en,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  busy,
  output logic                  expire
);

  logic [CNT_W-1:0] cnt_r;

  // ---------------------------------------------------------------
  // Crystal cycle counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || !enable || start)
      cnt_r <= '0;
    else if (busy && tick)
      cnt_r <= (cnt_r == limit - 1'b1) ? '0 : cnt_r + 1'b1; // RL16
  end

  always_ff @(posedge clk)
  begin
    if (rst || !enable)
      busy <= 1'b0;
    else if (start)
      busy <= 1'b1;
    else if (busy && tick && cnt_r == limit - 1'b1)
      busy <= repeat_en;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      expire <= 1'b0;
    else
      expire <= enable && !start && busy && tick && cnt_r == limit - 1'b1;
  end

  property p_expire_len;
    @(posedge clk) disable iff (rst)
      expire |-> $past(cnt_r) == $past(limit) - 1'b1 && $past(tick);
  endproperty
  a_expire_len: assert property (p_expire_len) // RL10
    else $error("Timer expired at the wrong count.");

endmodule : wop_xtal_timer

/* File: hdl/wop_option_reg.sv */
`timescale 1ns/100ps

// Operation
// RL1: Only the first software write after reset stores a value.
// RL2: Before the first write, reads return the default value.
// RL3: Later writes change nothing until the next reset.
// RL4: Undervolt reset needs nine consecutive low-supply cycles when enabled.
// RL5: Undervolt reset holds until the supply reaches the rising level.
// RL6: Undervolt-in-stop keeps the monitor running in stop mode when set.
// RL7: Monitor runs in stop only with power and in-stop both set.
// RL8: Reset enable passes the monitor's reset request only when set.
// RL9: Monitor power field powers the undervolt monitor when set.
// RL10: Fast wakeup selects 32 crystal cycles, else 4096.
// RL11: Software keeps fast wakeup clear with an external crystal.
// RL12: Short period selects 8176 crystal cycles, else 262128.
// RL13: The watchdog short-period field sits at bit two.
// RL14: Stop enable clear makes the stop instruction an illegal opcode.
// RL15: Watchdog disable set turns the watchdog unit off.
// RL16: Periods count crystal clock cycles at the crystal rate.
// RL17: Option fields drive neighbours as levels straight from the register.
// RL18: Any write, even of the default value, sets the lock.

module wop_option_reg #(
  parameter int unsigned XTAL_DIV  = 2,
  parameter int unsigned WDG_SHORT = wop_pkg::WDG_SHORT,
  parameter int unsigned WDG_LONG  = wop_pkg::WDG_LONG,
  parameter int unsigned UV_QUAL   = wop_pkg::UV_QUAL_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [wop_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [wop_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [wop_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       uv_below_falling,
  input  wire logic                       uv_above_rising,
  input  wire logic                       stop_mode,
  input  wire logic                       stop_exit_req,
  input  wire logic                       stop_opcode,
  input  wire logic                       wdg_service,
  output logic                            undervolt_monitor_power,
  output logic                            undervolt_active,
  output logic                            undervolt_reset,
  output logic                            fast_stop_wakeup,
  output logic                            stop_recovery_busy,
  output logic                            stop_recovered,
  output logic                            stop_instr_enable,
  output logic                            stop_illegal_opcode,
  output logic                            watchdog_enable,
  output logic                            watchdog_short_period,
  output logic                            watchdog_timeout,
  output logic                            crystal_clock_tick,
  output logic                            option_locked
);

  logic [7:0]  cfg_r;
  logic        lock_r;
  logic [1:0]  below_sync_r;
  logic [1:0]  above_sync_r;
  logic [7:0]  div_r;
  logic        uv_req;
  logic        cfg_wr;
  logic [17:0] stop_limit;
  logic [17:0] wdg_limit;

  // ---------------------------------------------------------------
  // Register write and lock
  // ---------------------------------------------------------------
  assign cfg_wr = reg_wr && reg_addr == wop_pkg::CFG_OFS;

  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_r <= wop_pkg::CFG_RESET; // RL2
    else if (cfg_wr && !lock_r) // RL3
      cfg_r <= reg_wdata & wop_pkg::CFG_MASK; // RL1
  end

  // The lock does not compare data, so rewriting the default still locks.
  always_ff @(posedge clk)
  begin
    if (rst)
      lock_r <= 1'b0;
    else if (cfg_wr)
      lock_r <= 1'b1; // RL18
  end

  assign option_locked = lock_r;

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  // Data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= 8'h00;
    else if (reg_addr == wop_pkg::CFG_OFS)
      reg_rdata <= cfg_r; // RL2
    else if (reg_addr == wop_pkg::STAT_OFS)
    begin
      reg_rdata                         <= 8'h00;
      reg_rdata[wop_pkg::STAT_LOCK]     <= lock_r;
      reg_rdata[wop_pkg::STAT_UV_RESET] <= undervolt_reset;
      reg_rdata[wop_pkg::STAT_STOP_REC] <= stop_recovery_busy;
      reg_rdata[wop_pkg::STAT_UV_BELOW] <= below_sync_r[1];
    end
    else
      reg_rdata <= 8'h00;
  end

  // ---------------------------------------------------------------
  // Option levels
  // ---------------------------------------------------------------
  assign undervolt_monitor_power = cfg_r[wop_pkg::BIT_UV_POWER]; // RL9
  assign fast_stop_wakeup        = cfg_r[wop_pkg::BIT_FAST_WAKE]; // RL17
  assign stop_instr_enable       = cfg_r[wop_pkg::BIT_STOP_ENABLE]; // RL17
  assign watchdog_enable         = !cfg_r[wop_pkg::BIT_WDG_DISABLE]; // RL15
  assign watchdog_short_period   = cfg_r[wop_pkg::BIT_WDG_SHORT]; // RL13

  // In stop mode the monitor runs only if both fields agree.
  assign undervolt_active = cfg_r[wop_pkg::BIT_UV_POWER] &&
                            (!stop_mode || cfg_r[wop_pkg::BIT_UV_IN_STOP]); // RL7

  // ---------------------------------------------------------------
  // Supply comparator synchronisers
  // ---------------------------------------------------------------
  // The comparators are analog and asynchronous to the bus clock.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      below_sync_r <= 2'b00;
      above_sync_r <= 2'b00;
    end
    else
    begin
      below_sync_r <= {below_sync_r[0], uv_below_falling};
      above_sync_r <= {above_sync_r[0], uv_above_rising};
    end
  end

  wop_uv_filter #(
    .QUAL          (UV_QUAL)
  ) u_uv_filter (
    .clk           (clk),
    .rst           (rst),
    .enable        (undervolt_active), // RL6
    .below_falling (below_sync_r[1]),
    .above_rising  (above_sync_r[1]),
    .reset_req     (uv_req)
  );

  assign undervolt_reset = uv_req && cfg_r[wop_pkg::BIT_UV_RST_EN]; // RL8

  // ---------------------------------------------------------------
  // Crystal clock enable
  // ---------------------------------------------------------------
  // One bus clock only; the crystal rate is an enable pulse.
  always_ff @(posedge clk)
  begin
    if (rst || div_r == 8'(XTAL_DIV - 1))
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end

  assign crystal_clock_tick = div_r == 8'(XTAL_DIV - 1); // RL16

  // ---------------------------------------------------------------
  // Stop recovery delay
  // ---------------------------------------------------------------
  // A fast wakeup with a slow-starting crystal would exit too early.
  assign stop_limit = fast_stop_wakeup ? 18'(wop_pkg::STOP_FAST)
                                       : 18'(wop_pkg::STOP_SLOW); // RL10

  wop_xtal_timer #(
    .CNT_W     (wop_pkg::CNT_W)
  ) u_stop_timer (
    .clk       (clk),
    .rst       (rst),
    .enable    (1'b1),
    .tick      (crystal_clock_tick),
    .start     (stop_exit_req && stop_mode && !stop_recovery_busy),
    .repeat_en (1'b0),
    .limit     (stop_limit),
    .busy      (stop_recovery_busy),
    .expire    (stop_recovered)
  );

  // ---------------------------------------------------------------
  // Watchdog period
  // ---------------------------------------------------------------
  logic wdg_busy;

  assign wdg_limit = watchdog_short_period ? 18'(WDG_SHORT) : 18'(WDG_LONG); // RL12

  wop_xtal_timer #(
    .CNT_W     (wop_pkg::CNT_W)
  ) u_wdg_timer (
    .clk       (clk),
    .rst       (rst),
    .enable    (watchdog_enable), // RL15
    .tick      (crystal_clock_tick),
    .start     (wdg_service || !wdg_busy),
    .repeat_en (1'b1),
    .limit     (wdg_limit),
    .busy      (wdg_busy),
    .expire    (watchdog_timeout)
  );

  // ---------------------------------------------------------------
  // Stop instruction check
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      stop_illegal_opcode <= 1'b0;
    else
      stop_illegal_opcode <= stop_opcode && !stop_instr_enable; // RL14
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_first_write;
    @(posedge clk) disable iff (rst)
      cfg_wr && !lock_r |=> cfg_r == ($past(reg_wdata) & wop_pkg::CFG_MASK);
  endproperty
  a_first_write: assert property (p_first_write) // RL1
    else $error("First option write was not stored.");

  property p_default_read;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == wop_pkg::CFG_OFS && !lock_r
        |=> reg_rdata == wop_pkg::CFG_RESET;
  endproperty
  a_default_read: assert property (p_default_read) // RL2
    else $error("Unlocked option register did not read default.");

  property p_locked;
    @(posedge clk) disable iff (rst)
      lock_r |=> $stable(cfg_r) && lock_r;
  endproperty
  a_locked: assert property (p_locked) // RL3
    else $error("Locked option register changed.");

  property p_lock_set;
    @(posedge clk) disable iff (rst)
      cfg_wr |=> lock_r;
  endproperty
  a_lock_set: assert property (p_lock_set) // RL18
    else $error("Write did not set the lock.");

  property p_uv_gate;
    @(posedge clk) disable iff (rst)
      undervolt_reset |-> uv_req && cfg_r[wop_pkg::BIT_UV_RST_EN];
  endproperty
  a_uv_gate: assert property (p_uv_gate) // RL8
    else $error("Undervolt reset passed while blocked.");

  property p_stop_off;
    @(posedge clk) disable iff (rst)
      stop_mode && !cfg_r[wop_pkg::BIT_UV_IN_STOP] |-> !undervolt_active;
  endproperty
  a_stop_off: assert property (p_stop_off) // RL7
    else $error("Undervolt monitor active in stop while disabled.");

  property p_illegal;
    @(posedge clk) disable iff (rst)
      stop_opcode |=> stop_illegal_opcode == !$past(stop_instr_enable);
  endproperty
  a_illegal: assert property (p_illegal) // RL14
    else $error("Stop opcode legality wrong.");

  property p_wdg_off;
    @(posedge clk) disable iff (rst)
      !watchdog_enable ##1 !watchdog_enable |-> !watchdog_timeout;
  endproperty
  a_wdg_off: assert property (p_wdg_off) // RL15
    else $error("Disabled watchdog timed out.");

  property p_short_bit;
    @(posedge clk) disable iff (rst)
      watchdog_short_period == cfg_r[2];
  endproperty
  a_short_bit: assert property (p_short_bit) // RL13
    else $error("Short period not taken from bit two.");

endmodule : wop_option_reg

/* File: sim/tb.sv */
`timescale 1ns/100ps

module tb;

  // ---------------------------------------------------------------
  // Stimulus table and bench state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] wdata;
    logic       smode;
    logic [7:0] rd;
    logic [5:0] lvl;
  } wop_row_t;

  localparam int NROW = 9;
  localparam wop_row_t ROWS [NROW] = '{
    '{8'h00, 1'b0, 8'h00, 6'h02}, '{8'hFF, 1'b1, 8'hBF, 6'h3D},
    '{8'h90, 1'b1, 8'h90, 6'h32}, '{8'h10, 1'b1, 8'h10, 6'h22},
    '{8'h80, 1'b1, 8'h80, 6'h02}, '{8'h04, 1'b0, 8'h04, 6'h03},
    '{8'h0A, 1'b0, 8'h0A, 6'h0E}, '{8'h10, 1'b0, 8'h10, 6'h32},
    '{8'h30, 1'b0, 8'h30, 6'h32}};

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       uv_below_falling = 1'b0;
  logic       uv_above_rising = 1'b0;
  logic       stop_mode = 1'b0;
  logic       stop_exit_req = 1'b0;
  logic       stop_opcode = 1'b0;
  logic       wdg_service = 1'b0;
  logic       uv_pwr, uv_act, uv_rst, fast, sbusy, srec, sen, sill, wen, wshort, wto, lck;
  logic       xtick;
  int         miscompares = 0;
  int         n_checks = 0;
  logic [7:0] d;
  int         n;

  always #10 clk = ~clk;

  // Watchdog counts are shortened so the whole run stays a few thousand cycles.
  wop_option_reg #(.XTAL_DIV(1), .WDG_SHORT(20), .WDG_LONG(40)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uv_below_falling(uv_below_falling),
    .uv_above_rising(uv_above_rising), .stop_mode(stop_mode), .stop_exit_req(stop_exit_req),
    .stop_opcode(stop_opcode), .wdg_service(wdg_service), .undervolt_monitor_power(uv_pwr),
    .undervolt_active(uv_act), .undervolt_reset(uv_rst), .fast_stop_wakeup(fast),
    .stop_recovery_busy(sbusy), .stop_recovered(srec), .stop_instr_enable(sen),
    .stop_illegal_opcode(sill), .watchdog_enable(wen), .watchdog_short_period(wshort),
    .watchdog_timeout(wto), .crystal_clock_tick(xtick), .option_locked(lck));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Holds the supply low for hold cycles and returns when the reset first showed.
  task automatic t_uv(input int hold, output int first);
    first = 0;
    @(posedge clk);
    uv_below_falling <= 1'b1;
    for (int i = 1; i <= 30; i++)
    begin
      @(posedge clk);
      if (i == hold)
        uv_below_falling <= 1'b0;
      #1 if (uv_rst === 1'b1 && first == 0) first = i;
    end
  endtask : t_uv

  // Bounded wait on a pulse; returns the cycles spent, or 9999 if it never came.
  task automatic wait_pulse(input int which, output int cnt);
    cnt = 9999;
    for (int i = 1; i <= 5000; i++)
    begin
      @(posedge clk);
      #1 if ((which == 0 ? srec : wto) === 1'b1)
      begin
        cnt = i;
        break;
      end
    end
  endtask : wait_pulse

  task automatic t_op(input logic exp);
    @(posedge clk);
    stop_opcode <= 1'b1;
    @(posedge clk);
    stop_opcode <= 1'b0;
    #1 check(sill, exp);
  endtask : t_op

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    do_reset();
    foreach (ROWS[r])
    begin
      do_reset();
      rd(wop_pkg::CFG_OFS, d);
      check(d, 8'h30);
      check(lck, 1'b0);
      wr(wop_pkg::CFG_OFS, ROWS[r].wdata);
      stop_mode <= ROWS[r].smode;
      rd(wop_pkg::CFG_OFS, d);
      check(d, ROWS[r].rd);
      check(lck, 1'b1);
      check({uv_pwr, uv_act, fast, sen, wen, wshort}, ROWS[r].lvl);
      wr(wop_pkg::CFG_OFS, ~ROWS[r].wdata);
      rd(wop_pkg::CFG_OFS, d);
      check(d, ROWS[r].rd);
      stop_mode <= 1'b0;
    end
    $display("test table done");

    do_reset();
    wr(wop_pkg::STAT_OFS, 8'hFF);
    check(lck, 1'b0);
    rd(4'h5, d);
    check(d, 8'h00);
    rd(wop_pkg::STAT_OFS, d);
    check(d[0], 1'b0);
    check(xtick, 1'b1);
    $display("test unmapped done");

    t_uv(8, n);
    check(n, 0);
    t_uv(30, n);
    check(n >= 9 && n <= 13, 1'b1);
    check(uv_rst, 1'b1);
    rd(wop_pkg::STAT_OFS, d);
    check(d[1], 1'b1);
    uv_above_rising <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(uv_rst, 1'b0);
    uv_above_rising <= 1'b0;
    do_reset();
    wr(wop_pkg::CFG_OFS, 8'h10);
    t_uv(30, n);
    check(n, 0);
    $display("test undervolt done");

    t_op(1'b1);
    do_reset();
    wr(wop_pkg::CFG_OFS, 8'h0A);
    t_op(1'b0);
    stop_mode <= 1'b1;
    stop_exit_req <= 1'b1;
    @(posedge clk);
    stop_exit_req <= 1'b0;
    #1 check(sbusy, 1'b1);
    wait_pulse(0, n);
    check(n >= 31 && n <= 34, 1'b1);
    do_reset();
    wr(wop_pkg::CFG_OFS, 8'h02);
    stop_exit_req <= 1'b1;
    @(posedge clk);
    stop_exit_req <= 1'b0;
    wait_pulse(0, n);
    check(n >= 4095 && n <= 4098, 1'b1);
    stop_mode <= 1'b0;
    $display("test stop done");

    for (int k = 0; k < 2; k++)
    begin
      do_reset();
      if (k == 1)
        wr(wop_pkg::CFG_OFS, 8'h04);
      wait_pulse(1, n);
      repeat (5) @(posedge clk);
      wdg_service <= 1'b1;
      @(posedge clk);
      wdg_service <= 1'b0;
      wait_pulse(1, n);
      check(n >= (k ? 19 : 39) && n <= (k ? 22 : 42), 1'b1);
    end
    do_reset();
    wr(wop_pkg::CFG_OFS, 8'h01);
    n = 0;
    repeat (100)
    begin
      @(posedge clk);
      #1 if (wto !== 1'b0) n++;
    end
    check(n, 0);
    $display("test watchdog done");
    give_verdict();
  end

  initial
  begin
    #1_000_000;
    miscompares++;
    give_verdict();
  end

endmodule : tb
